//--- core/wrac_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module wrac_fifo #(
    parameter int W     = 65,
    parameter int DEPTH = 16
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } wrac_fifo_state_t;
    wrac_fifo_state_t q, d;
    logic [W-1:0]     mem [DEPTH];
    logic             push;
    logic             pop;
    assign in_ready  = (q.cnt != CW'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        d = q;
        if (flush) begin
            d = '0;
        end else begin
            if (push) begin
                d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : AW'(q.wp + 1'b1);
            end
            if (pop) begin
                d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : AW'(q.rp + 1'b1);
            end
            d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    // storage needs no reset; count guards every read
    always_ff @(posedge clock) begin
        if (push && !flush) begin
            mem[q.wp] <= in_data;
        end
    end
endmodule // wrac_fifo
`default_nettype wire

//--- core/wrac_if.sv
`timescale 1ns/100ps
`default_nettype none
interface wrac_if;
    logic        wr_a;
    logic        wr_b;
    logic [10:0] wr_addr;
    logic [63:0] wr_data;
    logic [10:0] rd_addr;
    logic        rd_sel;
    logic [63:0] rd_data;
    logic [10:0] pl_addr;
    logic [63:0] pl_a;
    logic [63:0] pl_b;
    modport ctrl (output wr_a, wr_b, wr_addr, wr_data, rd_addr, rd_sel, pl_addr,
                  input rd_data, pl_a, pl_b);
    modport mem  (input wr_a, wr_b, wr_addr, wr_data, rd_addr, rd_sel, pl_addr,
                  output rd_data, pl_a, pl_b);
endinterface
`default_nettype wire

//--- core/wrac_pkg.sv
`default_nettype none
package wrac_pkg;
    localparam logic [8:0] WRAC_OFS_EVEN_CFG   = 9'h010;
    localparam logic [8:0] WRAC_OFS_EVEN_SETUP = 9'h012;
    localparam logic [8:0] WRAC_OFS_EVEN_QUAD  = 9'h013;
    localparam logic [8:0] WRAC_OFS_ODD_CFG    = 9'h020;
    localparam logic [8:0] WRAC_OFS_ODD_SETUP  = 9'h022;
    localparam logic [8:0] WRAC_OFS_ODD_QUAD   = 9'h023;
    localparam logic [8:0] WRAC_OFS_MISC       = 9'h1C4;
    localparam int WRAC_ADDR_W     = 11;
    localparam int WRAC_DEPTH      = 2048;
    localparam int WRAC_QUAD_W     = 64;
    localparam int WRAC_SETUP_W    = 26;
    localparam int WRAC_CFG_W      = 8;
    localparam int WRAC_FIFO_DEPTH = 16;
    localparam int WRAC_START_LSB  = 0;
    localparam int WRAC_BURST_LSB  = 11;
    localparam int WRAC_DIR_BIT    = 22;
    localparam int WRAC_BANK_BIT   = 23;
    localparam int WRAC_BOTH_BIT   = 24;
    localparam int WRAC_LAUNCH_BIT = 25;
    localparam int WRAC_SWRST_BIT  = 0;
    localparam int WRAC_INH_BIT    = 1;
    localparam int WRAC_GATE_BIT   = 1;
    localparam logic [7:0]  WRAC_CFG_RST   = 8'h02;
    localparam logic [25:0] WRAC_SETUP_RST = 26'h0000000;
    localparam logic        WRAC_GATE_RST  = 1'b1;
    typedef enum logic [1:0] {
        WRAC_IDLE = 2'b00,
        WRAC_PROG = 2'b01
    } wrac_state_t;
    typedef struct packed {
        wrac_state_t st;
        logic [7:0]  cfg;
        logic [25:0] setup;
        logic [10:0] addr;
        logic [10:0] cnt;
        logic [63:0] staged;
        logic        staged_v;
        logic [10:0] rptr;
        logic [10:0] rcnt;
        logic [10:0] pcnt;
    } wrac_phase_t;
    localparam wrac_phase_t WRAC_PHASE_RST = '{st: WRAC_IDLE, cfg: WRAC_CFG_RST,
                                               setup: WRAC_SETUP_RST, default: '0};
endpackage
`default_nettype wire

//--- core/wrac_ram.sv
`timescale 1ns/100ps
`default_nettype none
module wrac_ram
    import wrac_pkg::*;
(
    input  wire logic clock,
    wrac_if.mem       port
);
    logic [WRAC_QUAD_W-1:0] bank_a [WRAC_DEPTH];
    logic [WRAC_QUAD_W-1:0] bank_b [WRAC_DEPTH];
    always_ff @(posedge clock) begin
        if (port.wr_a) begin
            bank_a[port.wr_addr] <= port.wr_data;
        end
        if (port.wr_b) begin
            bank_b[port.wr_addr] <= port.wr_data;
        end
    end
    // playback reads both banks; serial read follows the bank pick
    assign port.pl_a    = bank_a[port.pl_addr];
    assign port.pl_b    = bank_b[port.pl_addr];
    assign port.rd_data = port.rd_sel ? bank_b[port.rd_addr] : bank_a[port.rd_addr];
endmodule // wrac_ram
`default_nettype wire

//--- core/wrac_top.sv
`timescale 1ns/100ps
`default_nettype none
module wrac_top
    import wrac_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [8:0]  reg_addr,
    input  wire logic [63:0] reg_wdata,
    output logic [63:0]      reg_rdata,
    output logic             reg_rvalid,
    output logic             quad_ready,
    output logic [1:0]       prog_busy,
    output logic [63:0]      even_a_quad,
    output logic [63:0]      even_b_quad,
    output logic [63:0]      odd_a_quad,
    output logic [63:0]      odd_b_quad
);
    // ==========================================================
    // reset release
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ==========================================================
    // state
    typedef struct packed {
        wrac_phase_t [1:0] ph;
        logic              gate;
        logic [63:0]       rdata;
        logic              rvalid;
        logic              qready;
        logic [1:0][63:0]  out_a;
        logic [1:0][63:0]  out_b;
    } wrac_top_state_t;
    wrac_top_state_t q, d;

    logic [1:0]        mw_a;
    logic [1:0]        mw_b;
    logic [1:0][10:0]  mw_addr;
    logic [1:0][63:0]  mw_data;
    logic [1:0][63:0]  ram_rd;
    logic [1:0][63:0]  pl_a;
    logic [1:0][63:0]  pl_b;
    logic [1:0]        launch;
    logic [1:0]        drain_ok;
    logic              swrst_fall;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [64:0]       fifo_out_data;
    logic              hp;
    logic              pop;

    function automatic logic [10:0] start_of(input logic [25:0] s);
        return s[WRAC_START_LSB +: WRAC_ADDR_W];
    endfunction
    function automatic logic [10:0] burst_of(input logic [25:0] s);
        return s[WRAC_BURST_LSB +: WRAC_ADDR_W];
    endfunction

    // ==========================================================
    // data word buffer
    // one shared queue, tagged with phase, so words stay in host order
    assign fifo_in_valid = reg_wr && ((reg_addr == WRAC_OFS_EVEN_QUAD) ||
                                      (reg_addr == WRAC_OFS_ODD_QUAD));
    assign hp  = fifo_out_data[64];
    assign pop = fifo_out_valid && fifo_out_ready;
    // decoded apart from next state so the drain gate has no loop through it
    assign launch[0] = reg_wr && (reg_addr == WRAC_OFS_EVEN_SETUP)
                       && reg_wdata[WRAC_LAUNCH_BIT] && reg_wdata[WRAC_DIR_BIT];
    assign launch[1] = reg_wr && (reg_addr == WRAC_OFS_ODD_SETUP)
                       && reg_wdata[WRAC_LAUNCH_BIT] && reg_wdata[WRAC_DIR_BIT];

    // launch owns the bank port in its cycle, so draining waits
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            drain_ok[p] = !q.gate && !q.ph[p].cfg[WRAC_INH_BIT] && !launch[p];
        end
        fifo_out_ready = drain_ok[hp];
    end

    wrac_fifo #(
        .W     (65),
        .DEPTH (WRAC_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .flush     (swrst_fall),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({reg_addr == WRAC_OFS_ODD_QUAD, reg_wdata}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ==========================================================
    // memories
    wrac_if mif [2] ();
    for (genvar g = 0; g < 2; g++) begin : g_mem
        wrac_ram u_ram (
            .clock (clock),
            .port  (mif[g].mem)
        );
        assign mif[g].wr_a    = mw_a[g];
        assign mif[g].wr_b    = mw_b[g];
        assign mif[g].wr_addr = mw_addr[g];
        assign mif[g].wr_data = mw_data[g];
        assign mif[g].rd_addr = q.ph[g].rptr;
        assign mif[g].rd_sel  = q.ph[g].setup[WRAC_BANK_BIT];
        assign mif[g].pl_addr = 11'(start_of(q.ph[g].setup) + q.ph[g].pcnt);
        assign ram_rd[g]      = mif[g].rd_data;
        assign pl_a[g]        = mif[g].pl_a;
        assign pl_b[g]        = mif[g].pl_b;
    end

    // ==========================================================
    // next state
    always_comb begin
        logic [25:0] ns;
        logic        p;
        ns         = '0;
        p          = 1'b0;
        d          = q;
        d.rvalid   = 1'b0;
        d.qready   = fifo_in_ready;
        swrst_fall = 1'b0;
        mw_a       = 2'b00;
        mw_b       = 2'b00;
        mw_addr    = '0;
        mw_data    = '0;
        p          = reg_addr[5];
        ns         = reg_wdata[WRAC_SETUP_W-1:0];
        // register writes
        if (reg_wr) begin
            case (reg_addr)
                WRAC_OFS_EVEN_CFG, WRAC_OFS_ODD_CFG: begin
                    d.ph[p].cfg = reg_wdata[WRAC_CFG_W-1:0];
                    if (q.ph[p].cfg[WRAC_SWRST_BIT] && !reg_wdata[WRAC_SWRST_BIT]) begin
                        swrst_fall = 1'b1;
                    end
                end
                WRAC_OFS_EVEN_SETUP, WRAC_OFS_ODD_SETUP: begin
                    d.ph[p].setup                  = ns;
                    d.ph[p].setup[WRAC_LAUNCH_BIT] = 1'b0;
                    d.ph[p].rptr                   = start_of(ns);
                    d.ph[p].rcnt                   = '0;
                end
                WRAC_OFS_MISC: begin
                    d.gate = reg_wdata[WRAC_GATE_BIT];
                end
                default: begin
                end
            endcase
        end
        // launch: a word staged before it becomes the first word
        for (int k = 0; k < 2; k++) begin
            if (launch[k]) begin
                d.ph[k].st       = WRAC_PROG;
                d.ph[k].addr     = start_of(ns);
                d.ph[k].cnt      = '0;
                d.ph[k].staged_v = 1'b0;
                if (q.ph[k].staged_v) begin
                    mw_a[k]    = ns[WRAC_BOTH_BIT] || !ns[WRAC_BANK_BIT];
                    mw_b[k]    = ns[WRAC_BOTH_BIT] || ns[WRAC_BANK_BIT];
                    mw_addr[k] = start_of(ns);
                    mw_data[k] = q.ph[k].staged;
                    if (burst_of(ns) == '0) begin
                        d.ph[k].st   = WRAC_IDLE;
                        d.ph[k].pcnt = '0;
                    end else begin
                        d.ph[k].addr = 11'(start_of(ns) + 11'h001);
                        d.ph[k].cnt  = 11'h001;
                    end
                end
            end
        end
        // words from the queue
        if (pop) begin
            if (q.ph[hp].st == WRAC_PROG) begin
                mw_a[hp]    = q.ph[hp].setup[WRAC_BOTH_BIT] || !q.ph[hp].setup[WRAC_BANK_BIT];
                mw_b[hp]    = q.ph[hp].setup[WRAC_BOTH_BIT] || q.ph[hp].setup[WRAC_BANK_BIT];
                mw_addr[hp] = q.ph[hp].addr;
                mw_data[hp] = fifo_out_data[63:0];
                if (q.ph[hp].cnt == burst_of(q.ph[hp].setup)) begin
                    d.ph[hp].st   = WRAC_IDLE;
                    d.ph[hp].pcnt = '0;
                end else begin
                    d.ph[hp].addr = 11'(q.ph[hp].addr + 11'h001);
                    d.ph[hp].cnt  = 11'(q.ph[hp].cnt + 11'h001);
                end
            end else begin
                // idle: held for the next launch, otherwise ignored
                d.ph[hp].staged   = fifo_out_data[63:0];
                d.ph[hp].staged_v = 1'b1;
            end
        end
        // register reads
        if (reg_rd) begin
            d.rvalid = 1'b1;
            d.rdata  = '0;
            case (reg_addr)
                WRAC_OFS_EVEN_CFG, WRAC_OFS_ODD_CFG: begin
                    d.rdata[WRAC_CFG_W-1:0] = q.ph[p].cfg;
                end
                WRAC_OFS_EVEN_SETUP, WRAC_OFS_ODD_SETUP: begin
                    d.rdata[WRAC_SETUP_W-1:0]   = q.ph[p].setup;
                    d.rdata[WRAC_LAUNCH_BIT]    = (q.ph[p].st == WRAC_PROG);
                end
                WRAC_OFS_EVEN_QUAD, WRAC_OFS_ODD_QUAD: begin
                    d.rdata = ram_rd[p];
                    if (!q.ph[p].setup[WRAC_DIR_BIT]) begin
                        if (q.ph[p].rcnt == burst_of(q.ph[p].setup)) begin
                            d.ph[p].rptr = start_of(q.ph[p].setup);
                            d.ph[p].rcnt = '0;
                        end else begin
                            d.ph[p].rptr = 11'(q.ph[p].rptr + 11'h001);
                            d.ph[p].rcnt = 11'(q.ph[p].rcnt + 11'h001);
                        end
                    end
                end
                WRAC_OFS_MISC: begin
                    d.rdata[WRAC_GATE_BIT] = q.gate;
                end
                default: begin
                end
            endcase
        end
        // playback: direction and bank pick play no part here
        for (int k = 0; k < 2; k++) begin
            if (q.ph[k].cfg[WRAC_INH_BIT]) begin
                d.ph[k].pcnt = '0;
                d.out_a[k]   = '0;
                d.out_b[k]   = '0;
            end else if (!q.gate) begin
                d.out_a[k] = pl_a[k];
                d.out_b[k] = pl_b[k];
                if ((q.ph[k].st == WRAC_IDLE) && (d.ph[k].st == WRAC_IDLE)) begin
                    if (q.ph[k].pcnt == burst_of(q.ph[k].setup)) begin
                        d.ph[k].pcnt = '0;
                    end else begin
                        d.ph[k].pcnt = 11'(q.ph[k].pcnt + 11'h001);
                    end
                end
            end
        end
        // soft reset aligns both phases and drops pending words
        if (swrst_fall) begin
            for (int k = 0; k < 2; k++) begin
                d.ph[k].st       = WRAC_IDLE;
                d.ph[k].staged_v = 1'b0;
                d.ph[k].pcnt     = '0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.ph[0]  <= WRAC_PHASE_RST;
            q.ph[1]  <= WRAC_PHASE_RST;
            q.gate   <= WRAC_GATE_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata    = q.rdata;
    assign reg_rvalid   = q.rvalid;
    assign quad_ready   = q.qready;
    assign prog_busy[0] = (q.ph[0].st == WRAC_PROG);
    assign prog_busy[1] = (q.ph[1].st == WRAC_PROG);
    assign even_a_quad  = q.out_a[0];
    assign even_b_quad  = q.out_b[0];
    assign odd_a_quad   = q.out_a[1];
    assign odd_b_quad   = q.out_b[1];

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_even_launch;
        reg_wr && (reg_addr == WRAC_OFS_EVEN_SETUP) && reg_wdata[WRAC_LAUNCH_BIT]
            && reg_wdata[WRAC_DIR_BIT];
    endsequence
    sequence s_even_last_word;
        pop && !hp && (q.ph[0].st == WRAC_PROG) && !swrst_fall
            && (q.ph[0].cnt == burst_of(q.ph[0].setup));
    endsequence
    sequence s_even_read;
        reg_rd && (reg_addr == WRAC_OFS_EVEN_QUAD) && !q.ph[0].setup[WRAC_DIR_BIT]
            && (q.ph[0].rcnt != burst_of(q.ph[0].setup));
    endsequence

    AST_START_LOAD: assert property (
        s_even_launch ##0 (reg_wdata[21:11] != 11'h000)
        |=> (q.ph[0].st == WRAC_PROG)
            && (q.ph[0].addr == 11'($past(reg_wdata[10:0]) + 11'($past(q.ph[0].staged_v))))
            && !q.ph[0].setup[WRAC_LAUNCH_BIT])
        else $error("launch did not load start address");
    AST_READ_NO_PROG: assert property (
        reg_wr && (reg_addr == WRAC_OFS_EVEN_SETUP) && !reg_wdata[WRAC_DIR_BIT]
            && (q.ph[0].st == WRAC_IDLE)
        |=> (q.ph[0].st == WRAC_IDLE))
        else $error("read mode setup entered programming");
    AST_BANK_ROUTE: assert property (
        pop && !hp && !reg_wr && (q.ph[0].st == WRAC_PROG)
        |-> (mw_a[0] == (q.ph[0].setup[WRAC_BOTH_BIT] || !q.ph[0].setup[WRAC_BANK_BIT]))
            && (mw_b[0] == (q.ph[0].setup[WRAC_BOTH_BIT] || q.ph[0].setup[WRAC_BANK_BIT])))
        else $error("write went to wrong bank");
    AST_BURST_END: assert property (
        s_even_last_word |=> (q.ph[0].st == WRAC_IDLE) && !prog_busy[0]
            && (q.ph[0].pcnt == 11'h000))
        else $error("sequence did not end at burst count");
    AST_SWRST_SYNC: assert property (
        swrst_fall |=> (q.ph[0].st == WRAC_IDLE) && (q.ph[1].st == WRAC_IDLE)
            && (q.ph[0].pcnt == 11'h000) && (q.ph[1].pcnt == 11'h000) && !fifo_out_valid)
        else $error("soft reset did not align both phases");
    AST_INHIBIT: assert property (
        q.ph[0].cfg[WRAC_INH_BIT] |=> (even_a_quad == 64'h0) && (even_b_quad == 64'h0))
        else $error("inhibited memory drove output");
    AST_GATE_FREEZE: assert property (
        q.gate && !swrst_fall |-> !fifo_out_ready ##1 $stable(q.ph[1].pcnt))
        else $error("gated module still active");
    AST_READ_STEP: assert property (
        s_even_read |=> (q.ph[0].rptr == 11'($past(q.ph[0].rptr) + 11'h001)) && reg_rvalid
            && (reg_rdata == $past(ram_rd[0])))
        else $error("serial read did not advance");
    AST_PLAY_STEP: assert property (
        (q.ph[0].st == WRAC_IDLE) && !q.gate && !q.ph[0].cfg[WRAC_INH_BIT] && !reg_wr
            && !(pop && !hp) && (q.ph[0].pcnt != burst_of(q.ph[0].setup))
        |=> (q.ph[0].pcnt == 11'($past(q.ph[0].pcnt) + 11'h001)))
        else $error("playback did not step");
    AST_PLAY_BANKS: assert property (
        !q.gate && !q.ph[1].cfg[WRAC_INH_BIT]
        // unwritten locations read unknown, so the copy is compared exactly
        |=> (odd_a_quad === $past(pl_a[1])) && (odd_b_quad === $past(pl_b[1])))
        else $error("playback output not from both banks");
endmodule // wrac_top
`default_nettype wire

//--- verif/test_waveform_ram_access_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module test_waveform_ram_access_ctrl;
    import wrac_pkg::*;
    // slots keep bits 0 and 15 clear
    localparam logic [63:0] W0 = 64'h1234_5678_2ABC_3DE2;
    localparam logic [63:0] W1 = 64'h0246_1358_7FFE_4002;
    logic        clock = 1'b0;
    logic        nrst  = 1'b0;
    logic        reg_wr;
    logic        reg_rd;
    logic [8:0]  reg_addr;
    logic [63:0] reg_wdata;
    logic [63:0] reg_rdata;
    logic        reg_rvalid;
    logic        quad_ready;
    logic [1:0]  prog_busy;
    logic [63:0] even_a_quad;
    logic [63:0] even_b_quad;
    logic [63:0] odd_a_quad;
    logic [63:0] odd_b_quad;
    logic [63:0] q;
    logic [63:0] a;
    int          num_errors = 0;
    int          tests_run  = 0;
    int          cycles     = 0;
    always #20 clock = ~clock;
    wrac_host wrac_host_inst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    wrac_top wrac_top_inst (.clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .quad_ready(quad_ready), .prog_busy(prog_busy),
        .even_a_quad(even_a_quad), .even_b_quad(even_b_quad), .odd_a_quad(odd_a_quad),
        .odd_b_quad(odd_b_quad));
    // ==========================================
    // helpers
    function automatic logic [63:0] setup(logic l, logic d, logic [10:0] b, logic [10:0] s);
        return 64'(l) << WRAC_LAUNCH_BIT | 64'(d) << WRAC_DIR_BIT | 64'(b) << WRAC_BURST_LSB
            | 64'(s);
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    // ==========================================
    // scenarios
    task automatic t_reset;
        wrac_host_inst.rd(WRAC_OFS_EVEN_SETUP, q);
        chk(q, 64'h0);
        chk(64'(reg_rvalid), 64'h1);
        @(negedge clock);
        chk(64'(reg_rvalid), 64'h0);
        chk(64'(quad_ready), 64'h1);
        chk(even_b_quad, 64'h0);
        wrac_host_inst.rd(WRAC_OFS_ODD_CFG, q);
        chk(q, 64'h02);
        wrac_host_inst.rd(WRAC_OFS_MISC, q);
        chk(q, 64'h02);
        wrac_host_inst.rd(9'h0FF, q);
        chk(q, 64'h0);
        $display("test reset values done");
    endtask
    task automatic t_prog;
        wrac_host_inst.wr(WRAC_OFS_MISC, 64'h0);
        wrac_host_inst.wr(WRAC_OFS_EVEN_CFG, 64'h0);
        wrac_host_inst.wr(WRAC_OFS_EVEN_QUAD, W0);
        wrac_host_inst.wr(WRAC_OFS_EVEN_SETUP, setup(1, 1, 11'h1, 11'h5));
        chk(64'(prog_busy[0]), 64'h1);
        wrac_host_inst.rd(WRAC_OFS_EVEN_SETUP, q);
        chk(q, setup(1, 1, 11'h1, 11'h5));
        wrac_host_inst.wr(WRAC_OFS_EVEN_QUAD, W1);
        for (int i = 0; i < 40 && prog_busy[0] !== 1'b0; i++) @(negedge clock);
        chk(64'(prog_busy[0]), 64'h0);
        wrac_host_inst.wr(WRAC_OFS_EVEN_QUAD, 64'h7FFE_7FFE_7FFE_7FFE);
        @(negedge clock);
        a = even_a_quad;
        @(negedge clock);
        chk(64'((a === W0 && even_a_quad === W1) || (a === W1 && even_a_quad === W0)), 64'h1);
        $display("test programming done");
    endtask
    task automatic t_read;
        wrac_host_inst.wr(WRAC_OFS_EVEN_SETUP, setup(0, 0, 11'h1, 11'h5));
        for (int i = 0; i < 3; i++) begin
            wrac_host_inst.rd(WRAC_OFS_EVEN_QUAD, q);
            chk(q, (i == 1) ? W1 : W0);
        end
        $display("test serial read done");
    endtask
    task automatic t_odd;
        wrac_host_inst.wr(WRAC_OFS_ODD_CFG, 64'h0);
        wrac_host_inst.wr(WRAC_OFS_ODD_QUAD, W1);
        // burst zero: the staged word alone completes the load, into both banks
        a = setup(1, 1, 11'h0, 11'h20) | (64'h1 << WRAC_BOTH_BIT);
        wrac_host_inst.wr(WRAC_OFS_ODD_SETUP, a);
        chk(64'(prog_busy[1]), 64'h0);
        repeat (2) @(negedge clock);
        chk(odd_a_quad, W1);
        chk(odd_b_quad, W1);
        $display("test odd phase done");
    endtask
    task automatic t_abort;
        wrac_host_inst.wr(WRAC_OFS_EVEN_SETUP, setup(1, 1, 11'h3, 11'h10));
        chk(64'(prog_busy[0]), 64'h1);
        // reset through the other phase keeps its inhibit set
        wrac_host_inst.wr(WRAC_OFS_ODD_CFG, 64'h03);
        chk(64'(prog_busy[0]), 64'h1);
        wrac_host_inst.wr(WRAC_OFS_ODD_CFG, 64'h02);
        @(negedge clock);
        chk(64'(prog_busy[0]), 64'h0);
        $display("test soft reset done");
    endtask
    initial begin
        repeat (20) @(negedge clock);
        nrst = 1'b1;
        repeat (3) @(negedge clock);
        t_reset();
        t_prog();
        t_read();
        t_odd();
        t_abort();
        // data source select lies beyond this block; a host flips it only now
        conclude();
    end
endmodule // test_waveform_ram_access_ctrl
`default_nettype wire

//--- verif/wrac_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host on the register port
module wrac_host (
    input  wire logic        clock,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [8:0]       reg_addr,
    output logic [63:0]      reg_wdata,
    input  wire logic [63:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 9'h000;
        reg_wdata = 64'h0;
    end
    // a free cycle after each request, as a slow serial host would leave
    task automatic wr(input logic [8:0] a, input logic [63:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [8:0] a, output logic [63:0] q);
        @(negedge clock);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clock);
        q        = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // wrac_host
`default_nettype wire
